// ---- design/uiw_pkg.sv ----
package uiw_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CTRL1  = 8'h04;
    localparam logic [7:0] OFF_CTRL2  = 8'h08;
    localparam logic [7:0] OFF_INTCTL = 8'h0c;

    // Reset values
    localparam logic [7:0] CTRL1_RST  = 8'h00;
    localparam logic [7:0] CTRL2_RST  = 8'h00;
    localparam logic [7:0] INTCTL_RST = 8'h00;

    // serial_status_reg fields
    localparam int ST_TXE = 0;
    localparam int ST_TXI = 1;
    localparam int ST_RXA = 2;
    localparam int ST_OVR = 3;

    // serial_control_reg_one fields
    localparam int C1_PORT_EN = 7;
    localparam int C1_NINTH   = 6;
    localparam int C1_PARITY  = 5;

    // serial_control_reg_two fields
    localparam int C2_TXE_IE = 7;
    localparam int C2_TXI_IE = 6;
    localparam int C2_RX_EN  = 5;
    localparam int C2_ADDR   = 4;
    localparam int C2_WAKE   = 3;
    localparam int C2_RIE    = 2;

    // Interrupt gate register fields
    localparam int IC_GLOBAL = 0;
    localparam int IC_MULTI  = 1;
    localparam int IC_SERIAL = 2;

    // Post-wake settle time in system clock cycles
    localparam int unsigned WAKE_DELAY_DEF = 1024;
    localparam int          DELAY_W        = 16;

    // Received word handed over from the receive datapath
    typedef struct packed {
        logic valid;
        logic bit8;
        logic bit9;
    } uiw_rxword_t;

    // One bit per interrupt condition
    typedef struct packed {
        logic txe;
        logic txi;
        logic rx;
        logic ovr;
        logic addr;
        logic wake;
    } uiw_evt_t;

    typedef enum logic [1:0] {
        WK_RUN,
        WK_ASLEEP,
        WK_SETTLE
    } uiw_wake_st_t;

endpackage

// ---- design/uiw_wake_timer.sv ----
`timescale 1ns/10ps
module uiw_wake_timer #(
    parameter int unsigned DELAY_CYCLES = uiw_pkg::WAKE_DELAY_DEF
) (
    // Clock and control
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    input  wire logic ce_in,
    // Start and status
    input  wire logic start_in,
    output logic      busy_out,
    output logic      done_out
);

    logic [uiw_pkg::DELAY_W-1:0] cnt_q;
    logic [uiw_pkg::DELAY_W-1:0] cnt_d;
    logic                        busy_q;
    logic                        busy_d;
    logic                        done_q;
    logic                        done_d;

    // Count down the settle time, one done pulse at the end
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start_in) begin
            cnt_d  = uiw_pkg::DELAY_W'(DELAY_CYCLES - 1);
            busy_d = 1'b1;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    // Registers, frozen while ce_in is low
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce_in) begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy_out = busy_q;
    assign done_out = done_q;

endmodule

// ---- design/uiw_core.sv ----
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
// Operation
// (RL1) Six interrupt conditions: tx empty, tx idle, rx data, overrun, address, wake.
// (RL2) Any enabled condition gives a one-cycle low pulse to the interrupt controller.
// (RL3) Pulse only with global, multifunction, serial enables set and stack not full.
// (RL4) Four conditions have status flags, each gated by an enable bit.
// (RL5) Tx empty and tx idle have own enables; rx data and overrun share one.
// (RL6) Address detect has no flag; interrupts on address when address detect enabled.
// (RL7) Clock off with enables set: rx falling edge raises a flagless wake interrupt.
// (RL8) Status flags read-only, not cleared by vectoring; cleared by status then data read.
// (RL9) Address detect mode: rx interrupt only when the top received bit is one.
// (RL10) Top bit is bit nine in nine-bit mode, else bit eight.
// (RL11) Address detect off: every received word requests an rx interrupt.
// (RL12) Software keeps parity off while address detect mode is on.
// (RL13) Clock off halts all activity; transmission resumes when clock returns.
// (RL14) Power-down during reception suspends it rather than aborting.
// (RL15) Power-down leaves status, control, data and divisor registers untouched.
// (RL16) Software lets transfers finish before entering power-down.
// (RL17) Data arriving during the post-wake settle time is discarded.
// (RL18) Without all interrupt enables a wake edge only wakes, no interrupt.
// (RL19) After a pin wake-up the interrupt waits until the settle time ends.
// (RL20) Rx data flag is set while the receive buffer holds a character.
// (RL21) Settle time is a parameter, defaulting to the oscillator start-up count.
module uiw_core #(
    parameter int unsigned WAKE_DELAY = uiw_pkg::WAKE_DELAY_DEF
) (
    // Clock, reset, enable
    input  wire logic                clk_in,
    input  wire logic                rst_b_in,
    input  wire logic                ce_in,
    // APB slave
    input  wire logic                psel_in,
    input  wire logic                penable_in,
    input  wire logic                pwrite_in,
    input  wire logic [7:0]          paddr_in,
    input  wire logic [31:0]         pwdata_in,
    output logic      [31:0]         prdata_out,
    output logic                     pready_out,
    output logic                     pslverr_out,
    // Datapath status and events
    input  wire logic                tx_empty_in,
    input  wire logic                tx_idle_in,
    input  wire logic                rx_buf_nonempty_in,
    input  wire uiw_pkg::uiw_rxword_t rx_word_in,
    input  wire logic                overrun_in,
    input  wire logic                data_read_in,
    // Pin, power and interrupt stack
    input  wire logic                rx_pin_in,
    input  wire logic                uart_clk_on_in,
    input  wire logic                stack_full_in,
    // Outputs to interrupt controller, system and datapath
    output logic                     int_req_b_out,
    output logic                     wake_out,
    output logic                     rx_discard_out,
    output logic                     uart_halt_out,
    output logic      [7:0]          ctrl1_out,
    output logic      [7:0]          ctrl2_out
);

    // Register state
    logic [7:0]  ctrl1_q, ctrl1_d;
    logic [7:0]  ctrl2_q, ctrl2_d;
    logic [7:0]  intctl_q, intctl_d;
    logic        ovr_q, ovr_d;
    logic        armed_q, armed_d;
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    // Event and wake state
    logic                  txe_prev_q, txe_prev_d;
    logic                  txi_prev_q, txi_prev_d;
    logic                  rx_prev_q, rx_prev_d;
    logic                  pend_q, pend_d;
    logic                  wake_int_q, wake_int_d;
    logic                  int_req_b_q, int_req_b_d;
    logic                  wake_q, wake_d;
    logic                  discard_q, discard_d;
    logic                  halt_q, halt_d;
    uiw_pkg::uiw_wake_st_t st_q, st_d;
    // Combinational helpers
    logic                  setup, access, hit, stat_rd, wr_ok;
    logic [7:0]            status;
    logic                  addr_bit, gates, rx_fall, wake_arm, fire, tmr_start;
    logic                  tmr_busy, tmr_done;
    uiw_pkg::uiw_evt_t     ev;

    uiw_wake_timer #(
        .DELAY_CYCLES (WAKE_DELAY)
    ) u_timer (
        .clk_in   (clk_in),
        .rst_b_in (rst_b_in),
        .ce_in    (ce_in),
        .start_in (tmr_start),
        .busy_out (tmr_busy),
        .done_out (tmr_done)
    );

    // Status image; flags follow hardware, software cannot write them
    always_comb begin
        status                  = 8'h00;
        status[uiw_pkg::ST_TXE] = tx_empty_in;
        status[uiw_pkg::ST_TXI] = tx_idle_in;
        status[uiw_pkg::ST_RXA] = rx_buf_nonempty_in;          // see RL20
        status[uiw_pkg::ST_OVR] = ovr_q;
    end

    // APB slave: data loaded in setup, pready high in the access cycle
    always_comb begin
        setup     = psel_in && !penable_in;
        access    = psel_in && penable_in && pready_q;
        hit       = (paddr_in == uiw_pkg::OFF_STATUS) || (paddr_in == uiw_pkg::OFF_CTRL1) ||
                    (paddr_in == uiw_pkg::OFF_CTRL2)  || (paddr_in == uiw_pkg::OFF_INTCTL);
        wr_ok     = access && pwrite_in && !pslverr_q;
        stat_rd   = access && !pwrite_in && (paddr_in == uiw_pkg::OFF_STATUS);
        pready_d  = setup;
        pslverr_d = setup && !hit;
        prdata_d  = 32'h0000_0000;
        if (setup && !pwrite_in) begin
            case (paddr_in)
                uiw_pkg::OFF_STATUS: prdata_d = {24'h00_0000, status};
                uiw_pkg::OFF_CTRL1:  prdata_d = {24'h00_0000, ctrl1_q};
                uiw_pkg::OFF_CTRL2:  prdata_d = {24'h00_0000, ctrl2_q};
                uiw_pkg::OFF_INTCTL: prdata_d = {24'h00_0000, intctl_q};
                default:             prdata_d = 32'h0000_0000;
            endcase
        end
        // Only writes change the control registers, never power state
        ctrl1_d  = ctrl1_q;                                     // see RL15
        ctrl2_d  = ctrl2_q;
        intctl_d = intctl_q;
        if (wr_ok && paddr_in == uiw_pkg::OFF_CTRL1) begin
            ctrl1_d = pwdata_in[7:0];
        end
        if (wr_ok && paddr_in == uiw_pkg::OFF_CTRL2) begin
            ctrl2_d = pwdata_in[7:0];
        end
        if (wr_ok && paddr_in == uiw_pkg::OFF_INTCTL) begin
            intctl_d = pwdata_in[7:0];
        end
        // Overrun clears by status read then data read; new overrun wins
        armed_d = data_read_in ? 1'b0 : (armed_q || stat_rd);   // see RL8
        ovr_d   = overrun_in || (ovr_q && !(armed_q && data_read_in));
    end

    // Interrupt conditions, gated by their enables
    always_comb begin
        addr_bit   = ctrl1_q[uiw_pkg::C1_NINTH] ? rx_word_in.bit9 : rx_word_in.bit8; // see RL10
        txe_prev_d = tx_empty_in;
        txi_prev_d = tx_idle_in;
        rx_prev_d  = rx_pin_in;
        ev.txe  = tx_empty_in && !txe_prev_q && ctrl2_q[uiw_pkg::C2_TXE_IE]; // see RL5
        ev.txi  = tx_idle_in && !txi_prev_q && ctrl2_q[uiw_pkg::C2_TXI_IE];  // see RL4
        // Rx data and overrun share one enable; rx data discarded while settling
        ev.rx   = rx_word_in.valid && !discard_q && ctrl2_q[uiw_pkg::C2_RIE] &&
                  (!ctrl2_q[uiw_pkg::C2_ADDR] || addr_bit);     // see RL9 see RL11
        ev.ovr  = overrun_in && !ovr_q && ctrl2_q[uiw_pkg::C2_RIE]; // see RL5
        ev.addr = rx_word_in.valid && !discard_q &&
                  ctrl2_q[uiw_pkg::C2_ADDR] && addr_bit;        // see RL6
        ev.wake = tmr_done && wake_int_q;                       // see RL7
        gates   = intctl_q[uiw_pkg::IC_GLOBAL] && intctl_q[uiw_pkg::IC_MULTI] &&
                  intctl_q[uiw_pkg::IC_SERIAL] && !stack_full_in; // see RL3
    end

    // Wake sequencer: asleep while clock off, settle after a line wake before running
    always_comb begin
        rx_fall    = rx_prev_q && !rx_pin_in;
        wake_arm   = ctrl1_q[uiw_pkg::C1_PORT_EN] && ctrl2_q[uiw_pkg::C2_RX_EN] &&
                     ctrl2_q[uiw_pkg::C2_RIE] && ctrl2_q[uiw_pkg::C2_WAKE];
        st_d       = st_q;
        wake_d     = 1'b0;
        tmr_start  = 1'b0;
        wake_int_d = wake_int_q;
        case (st_q)
            uiw_pkg::WK_RUN: begin
                if (!uart_clk_on_in) begin
                    st_d = uiw_pkg::WK_ASLEEP;                  // see RL13 see RL14
                end
            end
            uiw_pkg::WK_ASLEEP: begin
                if (rx_fall && wake_arm) begin
                    // Wake always; the interrupt is decided later by the gates
                    wake_d     = 1'b1;                          // see RL7 see RL18
                    wake_int_d = 1'b1;
                    tmr_start  = 1'b1;
                    st_d       = uiw_pkg::WK_SETTLE;
                end else if (uart_clk_on_in) begin
                    st_d = uiw_pkg::WK_RUN;
                end
            end
            uiw_pkg::WK_SETTLE: begin
                if (tmr_done) begin
                    wake_int_d = 1'b0;
                    st_d       = uiw_pkg::WK_RUN;               // see RL21
                end
            end
            default: begin
                st_d = uiw_pkg::WK_RUN;
            end
        endcase
        discard_d = (st_d == uiw_pkg::WK_SETTLE);               // see RL17
        halt_d    = (st_d != uiw_pkg::WK_RUN) || !uart_clk_on_in;
    end

    // Requests collect while settling and leave as a single low pulse
    always_comb begin
        pend_d      = pend_q || (|ev);                          // see RL1
        fire        = 1'b0;
        int_req_b_d = 1'b1;
        // A request right after a pulse waits a cycle so two pulses never merge
        if ((st_q == uiw_pkg::WK_RUN || ev.wake) && int_req_b_q) begin
            // Ungated requests are dropped, so a gated-off wake only wakes
            fire        = pend_d && gates;                      // see RL19 see RL18
            int_req_b_d = !fire;                                // see RL2
            pend_d      = 1'b0;
        end
    end

    // All state registers, frozen while ce_in is low
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            ctrl1_q     <= uiw_pkg::CTRL1_RST;
            ctrl2_q     <= uiw_pkg::CTRL2_RST;
            intctl_q    <= uiw_pkg::INTCTL_RST;
            ovr_q       <= 1'b0;
            armed_q     <= 1'b0;
            prdata_q    <= 32'h0000_0000;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            txe_prev_q  <= 1'b0;
            txi_prev_q  <= 1'b0;
            rx_prev_q   <= 1'b1;
            pend_q      <= 1'b0;
            wake_int_q  <= 1'b0;
            int_req_b_q <= 1'b1;
            wake_q      <= 1'b0;
            discard_q   <= 1'b0;
            halt_q      <= 1'b0;
            st_q        <= uiw_pkg::WK_RUN;
        end else if (ce_in) begin
            ctrl1_q     <= ctrl1_d;
            ctrl2_q     <= ctrl2_d;
            intctl_q    <= intctl_d;
            ovr_q       <= ovr_d;
            armed_q     <= armed_d;
            prdata_q    <= prdata_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            txe_prev_q  <= txe_prev_d;
            txi_prev_q  <= txi_prev_d;
            rx_prev_q   <= rx_prev_d;
            pend_q      <= pend_d;
            wake_int_q  <= wake_int_d;
            int_req_b_q <= int_req_b_d;
            wake_q      <= wake_d;
            discard_q   <= discard_d;
            halt_q      <= halt_d;
            st_q        <= st_d;
        end
    end

    // Outputs straight from flops
    assign prdata_out     = prdata_q;
    assign pready_out     = pready_q;
    assign pslverr_out    = pslverr_q;
    assign int_req_b_out  = int_req_b_q;
    assign wake_out       = wake_q;
    assign rx_discard_out = discard_q;
    assign uart_halt_out  = halt_q;
    assign ctrl1_out      = ctrl1_q;
    assign ctrl2_out      = ctrl2_q;

    // Checks, off in reset and while the clock enable freezes state
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in || !ce_in);

    sequence wake_edge_s;
        st_q == uiw_pkg::WK_ASLEEP && rx_fall && wake_arm;
    endsequence

    sequence settle_s;
        wake_out && rx_discard_out;
    endsequence

    AST_PULSE_ONE: assert property (!int_req_b_out |=> int_req_b_out) // see RL2
        else $error("interrupt pulse longer than one cycle");
    AST_GATED: assert property ($fell(int_req_b_out) |-> $past(gates)) // see RL3
        else $error("interrupt pulse without all enables");
    AST_ADDR_FILTER: assert property ( // see RL9
        rx_word_in.valid && ctrl2_q[uiw_pkg::C2_ADDR] && !addr_bit |-> !ev.rx && !ev.addr)
        else $error("data word raised interrupt in address mode");
    AST_NO_FILTER: assert property ( // see RL11
        rx_word_in.valid && !ctrl2_q[uiw_pkg::C2_ADDR] && ctrl2_q[uiw_pkg::C2_RIE] &&
        !discard_q |-> ev.rx)
        else $error("received word did not request interrupt");
    AST_WAKE_SEQ: assert property (wake_edge_s |=> settle_s ##1 !wake_out) // see RL7
        else $error("wake edge did not give one wake pulse");
    AST_WITHHOLD: assert property (st_q == uiw_pkg::WK_SETTLE && !tmr_done |=> // see RL19
        int_req_b_out)
        else $error("interrupt during settle time");
    AST_DISCARD: assert property (st_q == uiw_pkg::WK_SETTLE && !tmr_done |=> // see RL17
        rx_discard_out)
        else $error("rx data accepted during settle time");
    AST_OVR_STICKY: assert property (ovr_q && !(armed_q && data_read_in) |=> ovr_q) // see RL8
        else $error("overrun flag cleared without clear sequence");
    AST_HALT: assert property (!uart_clk_on_in |=> uart_halt_out) // see RL13
        else $error("activity not halted with clock off");
    AST_KEEP: assert property (st_q != uiw_pkg::WK_RUN && !wr_ok |=> // see RL15
        $stable(ctrl1_q) && $stable(ctrl2_q))
        else $error("control register changed in power-down");
    AST_SETTLE_TIMED: assert property (st_q == uiw_pkg::WK_SETTLE |-> // see RL21
        tmr_busy || tmr_done)
        else $error("settle state without a running timer");

endmodule

// ---- tb/uiw_far_model.sv ----
`timescale 1ns/10ps
// Far side: interrupt controller counting request pulses, plus the RX line
module uiw_far_model (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_b_in,
    // From the serial block
    input  wire logic int_req_b_in,
    input  wire logic wake_in,
    // Bench request for a start bit on the line
    input  wire logic rx_fall_req_in,
    // Line level and counts
    output logic      rx_pin_out,
    output int        int_count_out,
    output int        wake_count_out,
    output int        long_pulse_out
);
    logic       low_q;
    logic [2:0] hold_q;

    // Each low-going request counted once; a low longer than a cycle is flagged
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            low_q <= 1'b0;
            int_count_out <= 0;
            wake_count_out <= 0;
            long_pulse_out <= 0;
        end else begin
            low_q <= !int_req_b_in;
            if (!int_req_b_in && !low_q) int_count_out <= int_count_out + 1;
            if (!int_req_b_in && low_q) long_pulse_out <= long_pulse_out + 1;
            if (wake_in) wake_count_out <= wake_count_out + 1;
        end
    end

    // Line idles at the pulled-up mark level; a request drives a short start bit
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) hold_q <= 3'h0;
        else if (rx_fall_req_in) hold_q <= 3'h6;
        else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
    end
    assign rx_pin_out = (hold_q == 3'h0);
endmodule

// ---- tb/uiw_core_tb.sv ----
`timescale 1ns/10ps
// Self-checking bench for the serial interrupt and wake block
module uiw_core_tb;
    localparam int unsigned DLY = 8;  // Short settle time keeps the run brief
    typedef struct packed {
        logic [1:0] ev;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [2:0] ic;
        logic [3:0] fl;  // Stack full, bit8, bit9, expected pulse
    } uiw_row_t;
    logic        clk_in, rst_b_in, ce_in, psel_in, penable_in, pwrite_in, err;
    logic [7:0]  paddr_in, ctrl1_out, ctrl2_out;
    logic [31:0] pwdata_in, prdata_out, rdata;
    logic        pready_out, pslverr_out, tx_empty_in, tx_idle_in, rx_buf_nonempty_in;
    logic        overrun_in, data_read_in, rx_pin_in, uart_clk_on_in, stack_full_in;
    logic        int_req_b_out, wake_out, rx_discard_out, uart_halt_out, rx_fall_req;
    uiw_pkg::uiw_rxword_t rx_word_in;
    int          num_errors, samples_checked, int_cnt, wake_cnt, long_cnt, base;
    uiw_row_t    rows [17];

    uiw_core #(.WAKE_DELAY(DLY)) uiw_core_inst (
        .clk_in, .rst_b_in, .ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .tx_empty_in, .tx_idle_in,
        .rx_buf_nonempty_in, .rx_word_in, .overrun_in, .data_read_in, .rx_pin_in,
        .uart_clk_on_in, .stack_full_in, .int_req_b_out, .wake_out, .rx_discard_out,
        .uart_halt_out, .ctrl1_out, .ctrl2_out);

    uiw_far_model uiw_far_model_inst (
        .clk_in, .rst_b_in, .int_req_b_in(int_req_b_out), .wake_in(wake_out),
        .rx_fall_req_in(rx_fall_req), .rx_pin_out(rx_pin_in), .int_count_out(int_cnt),
        .wake_count_out(wake_cnt), .long_pulse_out(long_cnt));

    // 25 MHz system clock
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        rdata = prdata_out;
        err = pslverr_out;
        check(n < 20, 1, "bus answer");
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
        apb(1'b0, a, 32'h0);
        check(rdata, exp, "read data");
        check(err, eexp, "error response");
    endtask

    task automatic setup(input logic [7:0] c1, input logic [7:0] c2, input logic [2:0] ic);
        apb(1'b1, uiw_pkg::OFF_CTRL1, {24'h0, c1});
        apb(1'b1, uiw_pkg::OFF_CTRL2, {24'h0, c2});
        apb(1'b1, uiw_pkg::OFF_INTCTL, {29'h0, ic});
    endtask

    // Sleep, line wake, settle; transfers are already idle beforehand
    task automatic wake_run(input logic [2:0] ic, input int exp);
        int wb;
        setup(8'h80, 8'h2c, ic);
        base = int_cnt;
        wb = wake_cnt;
        @(posedge clk_in) uart_clk_on_in <= 1'b0;
        tick(3);
        check(uart_halt_out, 1, "halt while clock off");
        @(posedge clk_in) rx_fall_req <= 1'b1;
        @(posedge clk_in) rx_fall_req <= 1'b0;
        tick(4);
        check(wake_cnt - wb, 1, "wake pulse");
        check(rx_discard_out, 1, "discard in settle");
        @(posedge clk_in) rx_word_in <= 3'h4;
        uart_clk_on_in <= 1'b1;
        @(posedge clk_in) rx_word_in <= 3'h0;
        check(int_cnt - base, 0, "request held in settle");
        tick(DLY + 8);
        check(int_cnt - base, exp, "wake request count");
        check({rx_discard_out, uart_halt_out}, 0, "resumed");
        check({ctrl1_out, ctrl2_out}, 16'h802c, "control kept");
        $display("test wake with gates %h done", ic);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #800000;
        num_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        report_and_stop();
    end

    initial begin
        {rst_b_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
        {tx_empty_in, tx_idle_in, rx_buf_nonempty_in, overrun_in, data_read_in} = '0;
        {stack_full_in, rx_fall_req, rx_word_in, num_errors, samples_checked} = '0;
        ce_in = 1'b1;
        uart_clk_on_in = 1'b1;
        // Parity stays off in every address-detect row
        rows = '{'{2'h0, 8'h80, 8'h80, 3'h7, 4'h1}, '{2'h0, 8'h80, 8'h40, 3'h7, 4'h0},
                 '{2'h1, 8'h80, 8'h40, 3'h7, 4'h1}, '{2'h1, 8'h80, 8'h80, 3'h7, 4'h0},
                 '{2'h2, 8'h80, 8'h04, 3'h7, 4'h1}, '{2'h2, 8'h80, 8'h04, 3'h7, 4'h5},
                 '{2'h3, 8'h80, 8'h04, 3'h7, 4'h1}, '{2'h3, 8'h80, 8'hc0, 3'h7, 4'h0},
                 '{2'h2, 8'h80, 8'h14, 3'h7, 4'h0}, '{2'h2, 8'h80, 8'h14, 3'h7, 4'h5},
                 '{2'h2, 8'hc0, 8'h14, 3'h7, 4'h4}, '{2'h2, 8'hc0, 8'h14, 3'h7, 4'h3},
                 '{2'h2, 8'h80, 8'h10, 3'h7, 4'h5}, '{2'h0, 8'h80, 8'h80, 3'h3, 4'h0},
                 '{2'h0, 8'h80, 8'h80, 3'h5, 4'h0}, '{2'h0, 8'h80, 8'h80, 3'h6, 4'h0},
                 '{2'h0, 8'h80, 8'h80, 3'h7, 4'h8}};
        tick(3);
        rst_b_in <= 1'b1;
        check({int_req_b_out, wake_out, ctrl1_out, ctrl2_out}, 18'h20000, "reset outputs");
        rd_chk(uiw_pkg::OFF_CTRL1, {24'h0, uiw_pkg::CTRL1_RST}, 1'b0);
        rd_chk(uiw_pkg::OFF_CTRL2, {24'h0, uiw_pkg::CTRL2_RST}, 1'b0);
        rd_chk(uiw_pkg::OFF_INTCTL, {24'h0, uiw_pkg::INTCTL_RST}, 1'b0);
        rd_chk(uiw_pkg::OFF_STATUS, 32'h0, 1'b0);
        rd_chk(8'h10, 32'h0, 1'b1);
        $display("test reset and map done");
        // Event table: one condition per row, gated by enables and stack
        foreach (rows[i]) begin
            setup(rows[i].c1, rows[i].c2, rows[i].ic);
            stack_full_in <= rows[i].fl[3];
            base = int_cnt;
            @(posedge clk_in);
            case (rows[i].ev)
                2'h0: tx_empty_in <= 1'b1;
                2'h1: tx_idle_in <= 1'b1;
                2'h2: rx_word_in <= {1'b1, rows[i].fl[2], rows[i].fl[1]};
                default: overrun_in <= 1'b1;
            endcase
            @(posedge clk_in);
            rx_word_in <= 3'h0;
            overrun_in <= 1'b0;
            tick(3);
            {tx_empty_in, tx_idle_in} <= 2'b00;
            tick(3);
            check(int_cnt - base, rows[i].fl[0], "count");
            $display("test row %0d done", i);
        end
        stack_full_in <= 1'b0;
        // Status flags: read-only, overrun cleared by status read then data read
        rx_buf_nonempty_in <= 1'b1;
        @(posedge clk_in) overrun_in <= 1'b1;
        @(posedge clk_in) overrun_in <= 1'b0;
        apb(1'b1, uiw_pkg::OFF_STATUS, 32'h0);
        rd_chk(uiw_pkg::OFF_STATUS,
               (32'h1 << uiw_pkg::ST_RXA) | (32'h1 << uiw_pkg::ST_OVR), 1'b0);
        @(posedge clk_in) data_read_in <= 1'b1;
        @(posedge clk_in) data_read_in <= 1'b0;
        rd_chk(uiw_pkg::OFF_STATUS, 32'h1 << uiw_pkg::ST_RXA, 1'b0);
        $display("test status flags done");
        // Event while the clock is off is held until it returns
        setup(8'h80, 8'h80, 3'h7);
        base = int_cnt;
        @(posedge clk_in) uart_clk_on_in <= 1'b0;
        tick(3);
        @(posedge clk_in) tx_empty_in <= 1'b1;
        tick(4);
        check(int_cnt - base, 0, "no request while halted");
        @(posedge clk_in) uart_clk_on_in <= 1'b1;
        tick(6);
        check(int_cnt - base, 1, "held request issued");
        check(uart_halt_out, 0, "halt released");
        tx_empty_in <= 1'b0;
        $display("test clock off hold done");
        wake_run(3'h7, 1);
        wake_run(3'h0, 0);
        check(long_cnt, 0, "request pulse width");
        report_and_stop();
    end
endmodule
